/* File: far_top.sv */
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module far_top
   import far_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [15:0] d_pi_i,
   input wire logic [15:0] q_pi_i,
   input wire logic [15:0] est_angle_i,
   input wire logic [15:0] closed_duty_i,
   output logic [15:0] d_current_setpoint_o,
   output logic [15:0] q_current_setpoint_o,
   output logic [15:0] q_axis_voltage_o,
   output logic [15:0] angle_value_o,
   output logic [15:0] duty_o,
   output logic [15:0] sliding_gain_o,
   output logic [15:0] tracking_loop_prop_gain_o,
   output logic shunt_sampling_select_o,
   output logic match_o,
   output logic adc_trigger_o,
   output logic sample_window_o
);
   logic [7:0] ctrl_q;
   logic [7:0] stat_q;
   logic [7:0] rcnt_q;
   logic [15:0] qmax_q;
   logic [15:0] qmin_q;
   logic [15:0] ud_q;
   logic [15:0] reload_q;
   logic [15:0] swduty_q;
   logic [15:0] minwin_q;
   logic [15:0] trg_q;
   logic [15:0] force_q;
   logic [15:0] comp_q;
   logic [15:0] step_q;
   logic [15:0] accel_q;
   logic [14:1] fix_q;
   logic [14:0] gain_q;
   logic [15:0] match_q;
   logic [15:0] obs_q;
   logic [15:0] angle_q;
   logic fix_act_q;
   logic start_q;
   logic load_q;
   logic [15:0] obs_d;
   logic [15:0] fix_val;
   logic [15:0] rd_val;
   logic hi;
   logic uflow;
   logic [15:0] q_ax_q;
   logic [15:0] fix_wr;

   far_ramp_if rp ();

   assign hi = ~addr_i[0];
   assign fix_val = {1'b0, fix_q, 1'b1};
   // The fix register keeps only its middle bits; both end bits are fixed by hardware.
   assign fix_wr = far_put_byte(fix_val, hi, wdata_i);
   assign obs_d = est_angle_i + comp_q;
   assign q_axis_voltage_o = q_ax_q;
   assign angle_value_o = angle_q;

   // Plain software parameters written one byte at a time.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rcnt_q <= RST_BYTE;
         qmax_q <= 16'h0000;
         qmin_q <= 16'h0000;
         d_current_setpoint_o <= 16'h0000;
         q_current_setpoint_o <= 16'h0000;
         reload_q <= 16'h0000;
         swduty_q <= 16'h0000;
         minwin_q <= 16'h0000;
         trg_q <= 16'h0000;
         force_q <= 16'h0000;
         comp_q <= 16'h0000;
         step_q <= 16'h0000;
         accel_q <= 16'h0000;
         fix_q <= FIX_RST[14:1];
         gain_q <= 15'h0000;
         match_q <= 16'h0000;
      end else if (wr_i) begin
         unique case (addr_i)
            A_RAMP_CNT: rcnt_q <= wdata_i;
            A_QMAX_HI, A_QMAX_LO: qmax_q <= far_put_byte(qmax_q, hi, wdata_i);
            A_QMIN_HI, A_QMIN_LO: qmin_q <= far_put_byte(qmin_q, hi, wdata_i);
            A_IDREF_HI, A_IDREF_LO: begin
               d_current_setpoint_o <= far_put_byte(d_current_setpoint_o, hi, wdata_i);
            end
            A_IQREF_HI, A_IQREF_LO: begin
               q_current_setpoint_o <= far_put_byte(q_current_setpoint_o, hi, wdata_i);
            end
            A_RELOAD_HI, A_RELOAD_LO: reload_q <= far_put_byte(reload_q, hi, wdata_i);
            A_DUTY_HI, A_DUTY_LO: swduty_q <= far_put_byte(swduty_q, hi, wdata_i);
            A_WIN_HI, A_WIN_LO: minwin_q <= far_put_byte(minwin_q, hi, wdata_i);
            A_TRG_HI, A_TRG_LO: trg_q <= far_put_byte(trg_q, hi, wdata_i);
            A_ANGLE_HI, A_ANGLE_LO: force_q <= far_put_byte(force_q, hi, wdata_i);
            A_COMP_HI, A_COMP_LO: comp_q <= far_put_byte(comp_q, hi, wdata_i);
            A_STEP_HI, A_STEP_LO: step_q <= far_put_byte(step_q, hi, wdata_i);
            A_ACC_HI, A_ACC_LO: accel_q <= far_put_byte(accel_q, hi, wdata_i);
            A_FIX_HI, A_FIX_LO: fix_q <= fix_wr[14:1];
            A_GAIN_HI, A_GAIN_LO: gain_q <= 15'(far_put_byte({1'b0, gain_q}, hi, wdata_i));
            A_MATCH_HI, A_MATCH_LO: match_q <= far_put_byte(match_q, hi, wdata_i);
            default: ;
         endcase
      end
   end

   // Control bits; the ramp clears its own enable when it finishes.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q <= RST_BYTE;
         start_q <= 1'b0;
         load_q <= 1'b0;
      end else begin
         start_q <= wr_i && addr_i == A_CTRL && wdata_i[C_RAMP_EN] && !ctrl_q[C_RAMP_EN];
         load_q <= wr_i && (addr_i == A_STEP_HI || addr_i == A_STEP_LO);
         if (wr_i && addr_i == A_CTRL) begin
            ctrl_q <= {2'b00, wdata_i[5:0]};
         end else if (rp.done) begin
            ctrl_q[C_RAMP_EN] <= 1'b0;
         end
      end
   end

   // Sticky events, write one to clear; a new event in the clearing cycle wins.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stat_q <= RST_BYTE;
      end else begin
         if (wr_i && addr_i == A_STAT) begin
            stat_q <= stat_q & ~wdata_i & 8'h03;
         end
         if (match_o) begin
            stat_q[S_MATCH] <= 1'b1;
         end
         if (rp.done) begin
            stat_q[S_RAMP_DONE] <= 1'b1;
         end
      end
   end

   // Controller outputs: d follows its loop, q is held inside its limits.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ud_q <= 16'h0000;
         q_ax_q <= 16'h0000;
      end else begin
         ud_q <= d_pi_i;
         q_ax_q <= far_clamp(q_pi_i, qmin_q, qmax_q);
      end
   end

   // Duty mux and observer gain routing.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         duty_o <= 16'h0000;
         sliding_gain_o <= 16'h0000;
         tracking_loop_prop_gain_o <= 16'h0000;
         shunt_sampling_select_o <= 1'b0;
      end else begin
         duty_o <= ctrl_q[C_DUTY_SRC] ? swduty_q : closed_duty_i;
         sliding_gain_o <= ctrl_q[C_OBS_SEL] ? 16'h0000 : {1'b0, gain_q};
         tracking_loop_prop_gain_o <= ctrl_q[C_OBS_SEL] ? {1'b0, gain_q} : 16'h0000;
         shunt_sampling_select_o <= ctrl_q[C_SHUNT_SEL];
      end
   end

   // Angle source. Ramp updates add the fresh step; angles wrap at +-180 degrees.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         angle_q <= 16'h0000;
         obs_q <= 16'h0000;
         fix_act_q <= 1'b0;
      end else begin
         obs_q <= obs_d;
         if (start_q) begin
            fix_act_q <= 1'b0;
         end else if (rp.done && !ctrl_q[C_FORCE_MODE]) begin
            fix_act_q <= 1'b1;
         end
         if (ctrl_q[C_RAMP_EN]) begin
            if (rp.adv) begin
               angle_q <= angle_q + rp.step_hi;
            end
         end else if (ctrl_q[C_FORCE_MODE]) begin
            angle_q <= force_q;
         end else begin
            angle_q <= obs_d + (fix_act_q ? fix_val : 16'h0000);
         end
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb begin
      unique case (addr_i)
         A_RAMP_CNT: rd_val = {rcnt_q, 8'h00};
         A_QMAX_HI, A_QMAX_LO: rd_val = qmax_q;
         A_QMIN_HI, A_QMIN_LO: rd_val = qmin_q;
         A_UD_HI, A_UD_LO: rd_val = ud_q;
         A_UQ_HI, A_UQ_LO: rd_val = q_ax_q;
         A_IDREF_HI, A_IDREF_LO: rd_val = d_current_setpoint_o;
         A_IQREF_HI, A_IQREF_LO: rd_val = q_current_setpoint_o;
         A_RELOAD_HI, A_RELOAD_LO: rd_val = reload_q;
         A_DUTY_HI, A_DUTY_LO: rd_val = swduty_q;
         A_WIN_HI, A_WIN_LO: rd_val = minwin_q;
         A_TRG_HI, A_TRG_LO: rd_val = trg_q;
         A_ANGLE_HI, A_ANGLE_LO: rd_val = angle_q;
         A_COMP_HI, A_COMP_LO: rd_val = comp_q;
         A_STEP_HI, A_STEP_LO: rd_val = rp.step_hi;
         A_ACC_HI, A_ACC_LO: rd_val = accel_q;
         A_FIX_HI, A_FIX_LO: rd_val = fix_val;
         A_OBS_HI, A_OBS_LO: rd_val = obs_q;
         A_GAIN_HI, A_GAIN_LO: rd_val = {1'b0, gain_q};
         A_MATCH_HI, A_MATCH_LO: rd_val = match_q;
         A_CTRL: rd_val = {ctrl_q, 8'h00};
         A_STAT: rd_val = {stat_q, 8'h00};
         default: rd_val = 16'h0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= RST_BYTE;
      end else if (rd_i) begin
         rdata_o <= (hi || addr_i == A_RAMP_CNT || addr_i == A_CTRL || addr_i == A_STAT)
                    ? rd_val[15:8] : rd_val[7:0];
      end else begin
         rdata_o <= RST_BYTE;
      end
   end

   // Ramp generator paced by the carrier minimum.
   assign rp.tick = uflow;
   assign rp.start = start_q;
   assign rp.load = load_q;
   assign rp.load_val = step_q;
   assign rp.accel = accel_q;
   assign rp.count = rcnt_q;

   far_ramp #(
      .ACC_W(32)
   ) u_ramp (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .rp(rp)
   );

   far_carrier u_carrier (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .en_i(ctrl_q[C_CNT_EN]),
      .dual_i(ctrl_q[C_SHUNT_SEL]),
      .reload_i(reload_q),
      .match_i(match_q),
      .trg_i(trg_q),
      .min_win_i(minwin_q),
      .uflow_o(uflow),
      .match_o(match_o),
      .trig_o(adc_trigger_o),
      .window_o(sample_window_o)
   );

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence ramp_finish_s;
      rp.done && !(wr_i && addr_i == A_CTRL);
   endsequence
   sequence ramp_off_s;
      !ctrl_q[C_RAMP_EN] && stat_q[S_RAMP_DONE];
   endsequence

   q_clamp_a: assert property ($signed(qmin_q) <= $signed(qmax_q) && $stable(qmin_q)
      && $stable(qmax_q) |=> $signed(q_ax_q) <= $signed(qmax_q)
      && $signed(q_ax_q) >= $signed(qmin_q))
      else $error("q output left its limits");
   // The first edge after reset release still shows reset contents, so it is skipped.
   ud_follow_a: assert property ($past(rst_b_i) |-> ud_q == $past(d_pi_i))
      else $error("d output readback does not follow the loop");
   ud_read_a: assert property (rd_i && addr_i == A_UD_HI |=> rdata_o == $past(ud_q[15:8]))
      else $error("d output high byte read wrong");
   duty_sel_a: assert property ($past(rst_b_i) |-> duty_o ==
      ($past(ctrl_q[C_DUTY_SRC]) ? $past(swduty_q) : $past(closed_duty_i)))
      else $error("duty source select not obeyed");
   ramp_end_a: assert property (ramp_finish_s |=> ramp_off_s)
      else $error("ramp end did not clear enable and raise done");
   angle_add_a: assert property (ctrl_q[C_RAMP_EN] && rp.adv |=>
      angle_q == 16'($past(angle_q) + $past(rp.step_hi)))
      else $error("ramp update did not add the step to the angle");
   gain_top_a: assert property (!sliding_gain_o[15] && !tracking_loop_prop_gain_o[15])
      else $error("observer gain top bit is not zero");
   obs_sum_a: assert property ($past(rst_b_i) |->
      obs_q == 16'($past(est_angle_i) + $past(comp_q)))
      else $error("observer angle is not estimate plus offset");

   // A step write reaches the accumulator one cycle after the byte lands.
   step_load_a: assert property (load_q |=> rp.step_hi == $past(step_q))
      else $error("written ramp step was not loaded");

   // Force mode outside a ramp tracks the written angle every cycle.
   force_angle_a: assert property (ctrl_q[C_FORCE_MODE] && !ctrl_q[C_RAMP_EN] |=>
      angle_q == $past(force_q))
      else $error("force angle not applied");

   // A match pulse always leaves its sticky status bit set, even under a clear.
   match_seen_a: assert property (match_o |=> stat_q[S_MATCH])
      else $error("match event not recorded");

   // Leaving a ramp in estimator mode arms the handover fix.
   fix_arm_a: assert property (rp.done && !ctrl_q[C_FORCE_MODE] && !start_q |=> fix_act_q)
      else $error("handover fix not armed at ramp end");
endmodule // far_top

/* File: far_pkg.sv */
package far_pkg;
   // Register byte addresses; each 16-bit quantity is a high byte then a low byte.
   localparam logic [15:0] A_RAMP_CNT = 16'h408E;
   localparam logic [15:0] A_QMAX_HI = 16'h40A4;
   localparam logic [15:0] A_QMAX_LO = 16'h40A5;
   localparam logic [15:0] A_QMIN_HI = 16'h40A6;
   localparam logic [15:0] A_QMIN_LO = 16'h40A7;
   localparam logic [15:0] A_UD_HI = 16'h40A8;
   localparam logic [15:0] A_UD_LO = 16'h40A9;
   localparam logic [15:0] A_UQ_HI = 16'h40AA;
   localparam logic [15:0] A_UQ_LO = 16'h40AB;
   localparam logic [15:0] A_IDREF_HI = 16'h40AC;
   localparam logic [15:0] A_IDREF_LO = 16'h40AD;
   localparam logic [15:0] A_IQREF_HI = 16'h40AE;
   localparam logic [15:0] A_IQREF_LO = 16'h40AF;
   localparam logic [15:0] A_RELOAD_HI = 16'h40B0;
   localparam logic [15:0] A_RELOAD_LO = 16'h40B1;
   localparam logic [15:0] A_DUTY_HI = 16'h40B2;
   localparam logic [15:0] A_DUTY_LO = 16'h40B3;
   localparam logic [15:0] A_WIN_HI = 16'h40B4;
   localparam logic [15:0] A_WIN_LO = 16'h40B5;
   localparam logic [15:0] A_TRG_HI = 16'h40B6;
   localparam logic [15:0] A_TRG_LO = 16'h40B7;
   localparam logic [15:0] A_ANGLE_HI = 16'h40B8;
   localparam logic [15:0] A_ANGLE_LO = 16'h40B9;
   localparam logic [15:0] A_COMP_HI = 16'h40BA;
   localparam logic [15:0] A_COMP_LO = 16'h40BB;
   localparam logic [15:0] A_STEP_HI = 16'h40BC;
   localparam logic [15:0] A_STEP_LO = 16'h40BD;
   localparam logic [15:0] A_ACC_HI = 16'h40BE;
   localparam logic [15:0] A_ACC_LO = 16'h40BF;
   localparam logic [15:0] A_FIX_HI = 16'h40C0;
   localparam logic [15:0] A_FIX_LO = 16'h40C1;
   localparam logic [15:0] A_OBS_HI = 16'h40C2;
   localparam logic [15:0] A_OBS_LO = 16'h40C3;
   localparam logic [15:0] A_GAIN_HI = 16'h40C4;
   localparam logic [15:0] A_GAIN_LO = 16'h40C5;
   localparam logic [15:0] A_MATCH_HI = 16'h40E6;
   localparam logic [15:0] A_MATCH_LO = 16'h40E7;
   localparam logic [15:0] A_CTRL = 16'h40F0;
   localparam logic [15:0] A_STAT = 16'h40F1;
   // Control bit positions.
   localparam int C_CNT_EN = 0;
   localparam int C_DUTY_SRC = 1;
   localparam int C_SHUNT_SEL = 2;
   localparam int C_FORCE_MODE = 3;
   localparam int C_RAMP_EN = 4;
   localparam int C_OBS_SEL = 5;
   // Status bit positions.
   localparam int S_MATCH = 0;
   localparam int S_RAMP_DONE = 1;
   // Reset values and scaling.
   localparam logic [15:0] FIX_RST = 16'h0001;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int RAMP_SCALE_W = 8;

   // Replaces one byte of a 16-bit register.
   function automatic logic [15:0] far_put_byte(input logic [15:0] old, input logic hi,
                                                input logic [7:0] d);
      far_put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
   endfunction

   // Saturates a signed value; the lower limit wins when the limits cross.
   function automatic logic [15:0] far_clamp(input logic [15:0] v, input logic [15:0] lo,
                                             input logic [15:0] hi);
      logic [15:0] t;
      t = ($signed(v) > $signed(hi)) ? hi : v;
      far_clamp = ($signed(t) < $signed(lo)) ? lo : t;
   endfunction

   // Widens a signed 16-bit angle-format value to 32 bits.
   function automatic logic [31:0] far_sext32(input logic [15:0] a);
      far_sext32 = {{16{a[15]}}, a};
   endfunction
endpackage

/* File: far_ramp_if.sv */
`timescale 1ns/100ps
// Handshake between the register side and the ramp generator.
interface far_ramp_if;
   logic tick;
   logic start;
   logic load;
   logic [15:0] load_val;
   logic [15:0] accel;
   logic [7:0] count;
   logic [15:0] step_hi;
   logic adv;
   logic done;
   modport gen (input tick, start, load, load_val, accel, count, output step_hi, adv, done);
   modport ctl (output tick, start, load, load_val, accel, count, input step_hi, adv, done);
endinterface

/* File: far_ramp.sv */
`timescale 1ns/100ps
module far_ramp
   import far_pkg::*;
#(
   parameter int ACC_W = 32
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   far_ramp_if.gen rp
);
   if (ACC_W != 32) begin : g_chk
      $error("far_ramp supports only a 32-bit step accumulator");
   end

   logic [31:0] acc_q;
   logic [15:0] remain_q;
   logic busy_q;
   logic adv_q;
   logic done_q;

   // Accumulator: a load wins over an update so software sees its step at once.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_q <= 32'h00000000;
      end else if (rp.load) begin
         acc_q <= {rp.load_val, 16'h0000};
      end else if (busy_q && rp.tick) begin
         acc_q <= acc_q + far_sext32(rp.accel);
      end
   end

   // Update counter; a zero count finishes the ramp without any update.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         remain_q <= 16'h0000;
         busy_q <= 1'b0;
         adv_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         adv_q <= busy_q && rp.tick;
         done_q <= (rp.start && rp.count == 8'h00) || (busy_q && rp.tick && remain_q == 16'h0001);
         if (rp.start) begin
            remain_q <= {rp.count, {RAMP_SCALE_W{1'b0}}};
            busy_q <= rp.count != 8'h00;
         end else if (busy_q && rp.tick) begin
            remain_q <= remain_q - 16'h0001;
            busy_q <= remain_q != 16'h0001;
         end
      end
   end

   assign rp.step_hi = acc_q[31:16];
   assign rp.adv = adv_q;
   assign rp.done = done_q;

   accel_add_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      busy_q && rp.tick && !rp.load |=> acc_q == $past(acc_q) + far_sext32($past(rp.accel)))
      else $error("ramp accumulator did not add the widened acceleration");
endmodule // far_ramp

/* File: far_carrier.sv */
`timescale 1ns/100ps
module far_carrier
   import far_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic en_i,
   input wire logic dual_i,
   input wire logic [15:0] reload_i,
   input wire logic [15:0] match_i,
   input wire logic [15:0] trg_i,
   input wire logic [15:0] min_win_i,
   output logic uflow_o,
   output logic match_o,
   output logic trig_o,
   output logic window_o
);
   logic [15:0] cnt_q;
   logic up_q;
   logic [16:0] wcnt_q;
   logic [15:0] mag;
   logic fire;
   logic [32:0] prod;

   // Trigger point: sign or top bit picks the side of the minimum, the rest the distance.
   always_comb begin
      prod = 33'(min_win_i) * 33'({reload_i, 1'b0});
      if (dual_i) begin
         mag = (trg_i[14:0] > reload_i[14:0]) ? {1'b0, reload_i[14:0]} : {1'b0, trg_i[14:0]};
      end else begin
         mag = trg_i[15] ? 16'(-trg_i) : trg_i;
         if (mag > reload_i) begin
            mag = reload_i;
         end
      end
      fire = en_i && cnt_q == mag && (mag == 16'h0000 || up_q != trg_i[15]);
   end

   // Up/down carrier counter turning at the reload value and at zero.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= 16'h0000;
         up_q <= 1'b1;
      end else if (!en_i || reload_i == 16'h0000) begin
         cnt_q <= 16'h0000;
         up_q <= 1'b1;
      end else if (up_q) begin
         if (cnt_q >= reload_i) begin
            up_q <= 1'b0;
            cnt_q <= reload_i - 16'h0001;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end else if (cnt_q == 16'h0000) begin
         up_q <= 1'b1;
         cnt_q <= 16'h0001;
      end else begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   // Event pulses and the sampling window; the window never shrinks below one cycle.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         uflow_o <= 1'b0;
         match_o <= 1'b0;
         trig_o <= 1'b0;
         window_o <= 1'b0;
         wcnt_q <= 17'h00000;
      end else begin
         uflow_o <= en_i && reload_i != 16'h0000 && !up_q && cnt_q == 16'h0000;
         match_o <= en_i && cnt_q == match_i;
         trig_o <= fire;
         window_o <= fire || wcnt_q > 17'h00001;
         if (fire) begin
            wcnt_q <= (dual_i || prod[32:16] == 17'h00000) ? 17'h00001 : prod[32:16];
         end else if (wcnt_q != 17'h00000) begin
            wcnt_q <= wcnt_q - 17'h00001;
         end
      end
   end

   match_evt_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && cnt_q == match_i |=> match_o)
      else $error("counter equal to match value gave no match pulse");
   reload_turn_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && up_q && reload_i != 16'h0000 && cnt_q == reload_i && $stable(reload_i)
      |=> !up_q && cnt_q == $past(reload_i) - 16'h0001)
      else $error("counter did not turn at the reload value");
endmodule // far_carrier

/* File: far_loop_model.sv */
`timescale 1ns/100ps
// Stand-in for the current loop and the observer that feed the engine.
module far_loop_model #(
   parameter logic [15:0] EST = 16'h1000,
   parameter logic [15:0] DUTY = 16'h1234
) (
   input wire logic [15:0] q_req_i,
   output logic [15:0] d_pi_o,
   output logic [15:0] q_pi_o,
   output logic [15:0] est_angle_o,
   output logic [15:0] closed_duty_o
);
   // The d-axis output is the inverse so that a swapped readback shows up.
   assign q_pi_o = q_req_i;
   assign d_pi_o = ~q_req_i;
   assign est_angle_o = EST;
   assign closed_duty_o = DUTY;
endmodule // far_loop_model

/* File: foc_loop_angle_ramp_params_test.sv */
`timescale 1ns/100ps
module foc_loop_angle_ramp_params_test import far_pkg::*;;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00;
   logic [15:0] q_req = 16'h0000;
   logic [7:0] rdata_o;
   logic [15:0] d_pi, q_pi, est, cduty, dsp, qsp, qv, ang, duty, sg, tg;
   logic match_o;
   logic ssel, trig, win;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   // The engine and the loop model face each other on the level inputs.
   far_top u_far_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .d_pi_i(d_pi),
      .q_pi_i(q_pi), .est_angle_i(est), .closed_duty_i(cduty), .d_current_setpoint_o(dsp),
      .q_current_setpoint_o(qsp), .q_axis_voltage_o(qv), .angle_value_o(ang),
      .duty_o(duty), .sliding_gain_o(sg), .tracking_loop_prop_gain_o(tg),
      .shunt_sampling_select_o(ssel), .match_o(match_o), .adc_trigger_o(trig),
      .sample_window_o(win));
   far_loop_model u_far_loop_model (.q_req_i(q_req), .d_pi_o(d_pi), .q_pi_o(q_pi),
      .est_angle_o(est), .closed_duty_o(cduty));
   // Comparison helper; case inequality keeps unknowns from passing.
   task automatic ck(input string n, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   // Bus cycles: one strobe cycle each, read data taken in the following cycle.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic wr16(input logic [15:0] a, input logic [15:0] v);
      wr(a, v[15:8]);
      wr(a + 16'h0001, v[7:0]);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      ck("read data", {8'h00, e}, {8'h00, rdata_o});
   endtask
   // Lets registered outputs follow their inputs before they are judged.
   task automatic settle;
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic t_reset;
      rd(A_FIX_LO, 8'h01);
      rd(A_FIX_HI, 8'h00);
      rd(16'h4000, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_limits;
      wr16(A_QMIN_HI, 16'hFF9C);
      wr16(A_QMAX_HI, 16'h0064);
      q_req <= 16'h00C8;
      settle();
      ck("q clamp high", 16'h0064, qv);
      rd(A_QMIN_LO, 8'h9C);
      @(posedge clk_sys_i);
      q_req <= 16'hFED4;
      settle();
      ck("q clamp low", 16'hFF9C, qv);
      wr(A_UQ_LO, 8'h00);
      rd(A_UQ_LO, 8'h9C);
      rd(A_UD_LO, 8'h2B);
      rd(A_UD_HI, 8'h01);
      $display("limit test done");
   endtask
   task automatic t_params;
      wr16(A_IDREF_HI, 16'h8001);
      wr16(A_IQREF_HI, 16'h7FFF);
      wr16(A_DUTY_HI, 16'hABCD);
      settle();
      ck("d setpoint", 16'h8001, dsp);
      ck("q setpoint", 16'h7FFF, qsp);
      ck("closed duty", 16'h1234, duty);
      wr(A_CTRL, 8'h02);
      settle();
      ck("manual duty", 16'hABCD, duty);
      $display("parameter test done");
   endtask
   task automatic t_angle;
      wr(A_CTRL, 8'h08);
      wr16(A_ANGLE_HI, 16'h8000);
      settle();
      ck("force angle", 16'h8000, ang);
      rd(A_ANGLE_HI, 8'h80);
      wr16(A_COMP_HI, 16'h0010);
      rd(A_OBS_LO, 8'h10);
      rd(A_OBS_HI, 8'h10);
      wr16(A_GAIN_HI, 16'hFFFF);
      rd(A_GAIN_HI, 8'h7F);
      settle();
      ck("sliding gain", 16'h7FFF, sg);
      wr(A_CTRL, 8'h20);
      settle();
      ck("tracking gain", 16'h7FFF, tg);
      ck("sliding gain off", 16'h0000, sg);
      $display("angle test done");
   endtask
   // Reload 3 gives a six-cycle triangle passing 2 twice, so twelve cycles hold four matches.
   task automatic t_match;
      int k;
      k = 0;
      wr16(A_RELOAD_HI, 16'h0003);
      wr16(A_MATCH_HI, 16'h0002);
      wr(A_CTRL, 8'h01);
      repeat (8) @(posedge clk_sys_i);
      repeat (12) begin
         @(posedge clk_sys_i);
         #1;
         if (match_o === 1'b1) k++;
      end
      ck("match pulses", 16'h0004, 16'(k));
      $display("match test done");
   endtask
   // One count is 256 updates, one per six-cycle period, so the ramp ends near 1540 cycles.
   task automatic t_ramp;
      wr(A_RAMP_CNT, 8'h01);
      wr16(A_STEP_HI, 16'h0100);
      wr16(A_ACC_HI, 16'hFFFF);
      rd(A_STEP_HI, 8'h01);
      wr(A_CTRL, 8'h11);
      repeat (1500) @(posedge clk_sys_i);
      rd(A_CTRL, 8'h11);
      repeat (40) @(posedge clk_sys_i);
      rd(A_CTRL, 8'h01);
      rd(A_STAT, 8'h03);
      rd(A_STEP_LO, 8'hFF);
      ck("handover angle", 16'h1011, ang);
      $display("ramp test done");
   endtask
   // Counts trigger pulses and window cycles over two carrier periods.
   task automatic trig_count(input string n, input int et, input int ew);
      int t;
      int w;
      t = 0;
      w = 0;
      repeat (8) @(posedge clk_sys_i);
      repeat (12) begin
         @(posedge clk_sys_i);
         #1;
         t += int'(trig === 1'b1);
         w += int'(win === 1'b1);
      end
      ck({n, " triggers"}, 16'(et), 16'(t));
      ck({n, " window"}, 16'(ew), 16'(w));
   endtask
   // Half a period of minimum window over a six-cycle period gives three window cycles.
   task automatic t_trigger;
      wr16(A_WIN_HI, 16'h8000);
      trig_count("single", 2, 6);
      wr(A_CTRL, 8'h05);
      trig_count("dual", 2, 2);
      ck("shunt select", 16'h0001, {15'h0000, ssel});
      $display("trigger test done");
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // The tests need about two thousand cycles; this cuts a hang short.
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_limits();
      t_params();
      t_angle();
      t_match();
      t_ramp();
      t_trigger();
      end_of_test();
   end
endmodule // foc_loop_angle_ramp_params_test
